// [logic/sock_ctl_pkg.sv]
// Constants and types for the socket control and status block
// Contract
// [RULE_01] Low card-detect pins mean card seated
// [RULE_02] CardBus presence and type from detect plus sense; code reports a CardBus card only in CardBus mode
// [RULE_03] Enable one even bytes, two odd, both word
// [RULE_04] Eight-bit socket: enable one only, A0 picks byte
// [RULE_05] Sixteen-bit reset low normally, high resets card
// [RULE_06] Reset pin floats unless seated, powered, enabled
// [RULE_07] CardBus mode drives reset active low
// [RULE_08] Second battery pin: warning, speaker or audio
// [RULE_09] Second battery pin may be disk LED
// [RULE_10] Memory mode first battery pin is battery dead
// [RULE_11] I/O mode first battery pin is status change
// [RULE_12] Control bit seven makes it ring indicate
// [RULE_13] CardBus card signals changes on status pin
// [RULE_14] Decode both sense pins for card voltage
// [RULE_15] Sense pull-ups from data-write and pull-up bits
// [RULE_16] Per-socket mode routes every multi-function pin
package sock_ctl_pkg;

  localparam int unsigned NUM_SOCK = 2;
  localparam int unsigned AW       = 4;
  localparam int unsigned DW       = 32;

  // Register offsets (byte addresses)
  localparam logic [AW-1:0] OFF_CTRL0  = 4'h0;
  localparam logic [AW-1:0] OFF_CTRL1  = 4'h4;
  localparam logic [AW-1:0] OFF_STAT0  = 4'h8;
  localparam logic [AW-1:0] OFF_STAT1  = 4'hC;
  localparam logic [AW-1:0] OFF_IRQ_ST = 4'h1;
  localparam logic [AW-1:0] OFF_IRQ_MK = 4'h2;

  // Socket control register fields
  localparam int unsigned CF_MODE_LO   = 0;
  localparam int unsigned CF_BUS8      = 2;
  localparam int unsigned CF_RESET     = 3;
  localparam int unsigned CF_PWR       = 4;
  localparam int unsigned CF_IFEN      = 5;
  localparam int unsigned CF_SPKR      = 6;
  localparam int unsigned CF_RING      = 7;
  localparam int unsigned CF_LED       = 8;
  localparam int unsigned CF_XDW       = 9;
  localparam int unsigned CF_CDPU      = 10;
  localparam int unsigned CTRL_W       = 11;

  // Status register fields
  localparam int unsigned SF_PRESENT   = 0;
  localparam int unsigned SF_CBCARD    = 1;
  localparam int unsigned SF_VOLT_LO   = 2;
  localparam int unsigned SF_BATDEAD   = 4;
  localparam int unsigned SF_BATWARN   = 5;
  localparam int unsigned SF_STSCHG    = 6;
  localparam int unsigned SF_RING      = 7;
  localparam int unsigned SF_LED       = 8;
  localparam int unsigned SF_AUDIO     = 9;
  localparam int unsigned STAT_W       = 10;

  // Event bits per socket: insert, remove, status change, ring
  localparam int unsigned EV_PER_SOCK  = 4;
  localparam int unsigned EV_INS       = 0;
  localparam int unsigned EV_REM       = 1;
  localparam int unsigned EV_STS       = 2;
  localparam int unsigned EV_RING      = 3;
  localparam int unsigned EV_W         = NUM_SOCK * EV_PER_SOCK;

  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [EV_W-1:0]   MASK_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO  = 2'b01,
    MODE_CB  = 2'b10
  } sock_mode_t;

  // Voltage codes from the sense pin pair
  localparam logic [1:0] VOLT_5V   = 2'b11;
  localparam logic [1:0] VOLT_3V   = 2'b10;
  localparam logic [1:0] VOLT_XV   = 2'b01;
  localparam logic [1:0] VOLT_LOW  = 2'b00;

endpackage

// [logic/sock_ctl.sv]
// Dual-socket card control and status signalling
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module sock_ctl
  import sock_ctl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  clk_en_i,
  // Register port
  input  wire logic [AW-1:0]         reg_addr_i,
  input  wire logic [DW-1:0]         reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [DW-1:0]         reg_rdata_o,
  output logic                       irq_o,
  // Access request from the host side
  input  wire logic [NUM_SOCK-1:0]   acc_req_i,
  input  wire logic [NUM_SOCK-1:0]   acc_word_i,
  input  wire logic [NUM_SOCK-1:0]   acc_a0_i,
  // Socket pins
  input  wire logic [NUM_SOCK-1:0]   cd1_n_i,
  input  wire logic [NUM_SOCK-1:0]   cd2_n_i,
  input  wire logic [NUM_SOCK-1:0]   vs1_i,
  input  wire logic [NUM_SOCK-1:0]   vs2_i,
  input  wire logic [NUM_SOCK-1:0]   bvd1_i,
  input  wire logic [NUM_SOCK-1:0]   bvd2_i,
  output logic      [NUM_SOCK-1:0]   ce1_n_o,
  output logic      [NUM_SOCK-1:0]   ce2_n_o,
  output logic      [NUM_SOCK-1:0]   card_rst_o,
  output logic      [NUM_SOCK-1:0]   card_rst_oe_o,
  output logic      [NUM_SOCK-1:0]   vs_pu_en_o,
  output logic      [NUM_SOCK-1:0]   spkr_o,
  output logic      [NUM_SOCK-1:0]   led_o,
  output logic      [NUM_SOCK-1:0]   wake_o
);

  typedef struct packed {
    logic [NUM_SOCK-1:0][CTRL_W-1:0] ctrl;
    logic [NUM_SOCK-1:0][STAT_W-1:0] stat;
    logic [EV_W-1:0]                 ev;
    logic [EV_W-1:0]                 mask;
    logic [DW-1:0]                   rdata;
    logic                            irq;
    logic [NUM_SOCK-1:0]             ce1_n;
    logic [NUM_SOCK-1:0]             ce2_n;
    logic [NUM_SOCK-1:0]             rst;
    logic [NUM_SOCK-1:0]             rst_oe;
    logic [NUM_SOCK-1:0]             vs_pu;
    logic [NUM_SOCK-1:0]             spkr;
    logic [NUM_SOCK-1:0]             led;
    logic [NUM_SOCK-1:0]             wake;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Per-socket combinational decode
  logic [NUM_SOCK-1:0][STAT_W-1:0] stat_now;
  logic [NUM_SOCK-1:0]             rst_lvl;
  logic [NUM_SOCK-1:0]             rst_drv;
  logic [NUM_SOCK-1:0]             ce1_now;
  logic [NUM_SOCK-1:0]             ce2_now;
  logic [NUM_SOCK-1:0]             pu_now;
  logic [NUM_SOCK-1:0]             spkr_now;
  logic [NUM_SOCK-1:0]             led_now;
  logic [NUM_SOCK-1:0]             stsin;
  logic [NUM_SOCK-1:0]             ringin;

  genvar g;
  generate
    for (g = 0; g < NUM_SOCK; g++) begin : g_sock
      sock_mode_t mode;
      logic       seated;
      logic [CTRL_W-1:0] c;
      assign c      = st_r.ctrl[g];
      assign mode   = sock_mode_t'(c[CF_MODE_LO +: 2]); // RULE_16
      // Both detect pins low means seated
      assign seated = ~cd1_n_i[g] & ~cd2_n_i[g]; // RULE_01

      always_comb begin
        stat_now[g] = '0;
        stat_now[g][SF_PRESENT] = seated; // RULE_02
        // CardBus card: VS pins read as sense pair in CardBus mode
        stat_now[g][SF_CBCARD] = seated && (mode == MODE_CB) &&
                                 !(vs1_i[g] && vs2_i[g]); // RULE_02
        stat_now[g][SF_VOLT_LO +: 2] = {vs2_i[g], vs1_i[g]}; // RULE_14
        stat_now[g][SF_BATDEAD] = (mode == MODE_MEM) & ~bvd1_i[g]; // RULE_10
        stat_now[g][SF_BATWARN] = (mode == MODE_MEM) & ~bvd2_i[g]; // RULE_08
        stat_now[g][SF_STSCHG]  = stsin[g];
        stat_now[g][SF_RING]    = ringin[g];
        stat_now[g][SF_LED]     = led_now[g];
        stat_now[g][SF_AUDIO]   = (mode == MODE_CB) & bvd2_i[g]; // RULE_08
      end

      // Status pin: status change, or ring indicate in I/O mode when bit 7 set
      assign ringin[g] = c[CF_RING] & (mode == MODE_IO) &
                         ~bvd1_i[g]; // RULE_12
      assign stsin[g]  = ~c[CF_RING] & (mode != MODE_MEM) &
                         ~bvd1_i[g]; // RULE_11 RULE_13
      assign spkr_now[g] = (mode == MODE_IO) & c[CF_SPKR] &
                           ~bvd2_i[g]; // RULE_08
      assign led_now[g]  = (mode != MODE_CB) & c[CF_LED] &
                           ~bvd2_i[g]; // RULE_09

      // Card enables: word both, byte by A0, 8-bit only CE1
      always_comb begin
        ce1_now[g] = 1'b1;
        ce2_now[g] = 1'b1;
        if (acc_req_i[g] && mode != MODE_CB) begin
          if (c[CF_BUS8]) begin
            ce1_now[g] = 1'b0; // RULE_04
          end else if (acc_word_i[g]) begin
            ce1_now[g] = 1'b0; // RULE_03
            ce2_now[g] = 1'b0;
          end else begin
            ce1_now[g] = acc_a0_i[g]; // RULE_03
            ce2_now[g] = ~acc_a0_i[g];
          end
        end
      end

      // Reset level: high resets 16-bit card, low resets CardBus card
      assign rst_lvl[g] = (mode == MODE_CB) ? ~c[CF_RESET] // RULE_07
                                            : c[CF_RESET]; // RULE_05
      assign rst_drv[g] = seated & c[CF_PWR] & c[CF_IFEN]; // RULE_06
      assign pu_now[g]  = c[CF_XDW] & c[CF_CDPU]; // RULE_15
    end
  endgenerate

  always_comb begin
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    st_nxt = st_r;
    ev_set = '0;
    ev_clr = '0;
    for (int s = 0; s < NUM_SOCK; s++) begin
      ev_set[s*EV_PER_SOCK+EV_INS]  = stat_now[s][SF_PRESENT] &
                                      ~st_r.stat[s][SF_PRESENT];
      ev_set[s*EV_PER_SOCK+EV_REM]  = ~stat_now[s][SF_PRESENT] &
                                      st_r.stat[s][SF_PRESENT];
      ev_set[s*EV_PER_SOCK+EV_STS]  = stsin[s] & ~st_r.stat[s][SF_STSCHG];
      ev_set[s*EV_PER_SOCK+EV_RING] = ringin[s] & ~st_r.stat[s][SF_RING];
    end
    st_nxt.stat   = stat_now;
    st_nxt.ce1_n  = ce1_now;
    st_nxt.ce2_n  = ce2_now;
    st_nxt.rst    = rst_lvl & rst_drv;
    st_nxt.rst_oe = rst_drv;
    st_nxt.vs_pu  = pu_now;
    st_nxt.spkr   = spkr_now;
    st_nxt.led    = led_now;
    st_nxt.wake   = ringin;
    st_nxt.rdata  = '0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_CTRL0:  st_nxt.ctrl[0] = reg_wdata_i[CTRL_W-1:0];
        OFF_CTRL1:  st_nxt.ctrl[1] = reg_wdata_i[CTRL_W-1:0];
        OFF_IRQ_ST: ev_clr = reg_wdata_i[EV_W-1:0];
        OFF_IRQ_MK: st_nxt.mask = reg_wdata_i[EV_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_CTRL0:  st_nxt.rdata[CTRL_W-1:0] = st_r.ctrl[0];
        OFF_CTRL1:  st_nxt.rdata[CTRL_W-1:0] = st_r.ctrl[1];
        OFF_STAT0:  st_nxt.rdata[STAT_W-1:0] = st_r.stat[0];
        OFF_STAT1:  st_nxt.rdata[STAT_W-1:0] = st_r.stat[1];
        OFF_IRQ_ST: st_nxt.rdata[EV_W-1:0]   = st_r.ev;
        OFF_IRQ_MK: st_nxt.rdata[EV_W-1:0]   = st_r.mask;
        default:    st_nxt.rdata = '0;
      endcase
    end
    // Set wins over a same-cycle clear
    st_nxt.ev  = (st_r.ev & ~ev_clr) | ev_set;
    st_nxt.irq = |(st_nxt.ev & st_nxt.mask);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= '0;
      st_r.ctrl  <= {NUM_SOCK{CTRL_RST}};
      st_r.mask  <= MASK_RST;
      st_r.ce1_n <= '1;
      st_r.ce2_n <= '1;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o   = st_r.rdata;
  assign irq_o         = st_r.irq;
  assign ce1_n_o       = st_r.ce1_n;
  assign ce2_n_o       = st_r.ce2_n;
  assign card_rst_o    = st_r.rst;
  assign card_rst_oe_o = st_r.rst_oe;
  assign vs_pu_en_o    = st_r.vs_pu;
  assign spkr_o        = st_r.spkr;
  assign led_o         = st_r.led;
  assign wake_o        = st_r.wake;

endmodule

// [dv/sock_ctl_properties.sv]
// Port-level checks of the socket control block
`timescale 1ns/1ps
module sock_ctl_properties
  import sock_ctl_pkg::*;
(
  // Clock, reset, enable
  input wire logic                core_clk_i,
  input wire logic                rst_n_i,
  input wire logic                clk_en_i,
  // Register port
  input wire logic                reg_rd_i,
  input wire logic [DW-1:0]       reg_rdata_o,
  input wire logic                irq_o,
  // Socket side
  input wire logic [NUM_SOCK-1:0] acc_req_i,
  input wire logic [NUM_SOCK-1:0] acc_word_i,
  input wire logic [NUM_SOCK-1:0] acc_a0_i,
  input wire logic [NUM_SOCK-1:0] cd1_n_i,
  input wire logic [NUM_SOCK-1:0] cd2_n_i,
  input wire logic [NUM_SOCK-1:0] bvd1_i,
  input wire logic [NUM_SOCK-1:0] bvd2_i,
  input wire logic [NUM_SOCK-1:0] ce1_n_o,
  input wire logic [NUM_SOCK-1:0] ce2_n_o,
  input wire logic [NUM_SOCK-1:0] card_rst_o,
  input wire logic [NUM_SOCK-1:0] card_rst_oe_o,
  input wire logic [NUM_SOCK-1:0] led_o,
  input wire logic [NUM_SOCK-1:0] wake_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  rdata_gap_a: assert property (clk_en_i && !reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  freeze_hold_a: assert property (!clk_en_i |=> $stable(ce1_n_o) &&
    $stable(card_rst_o) && $stable(irq_o))
    else $error("outputs moved while frozen");
  for (genvar s = 0; s < NUM_SOCK; s++) begin : g_sock
    ce_idle_a: assert property (
      clk_en_i && !acc_req_i[s] |=> ce1_n_o[s] && ce2_n_o[s])
      else $error("card enable without access");
    ce_odd_a: assert property (
      $past(clk_en_i) && !ce2_n_o[s] |->
      $past(acc_req_i[s] && (acc_word_i[s] || acc_a0_i[s])))
      else $error("second enable without odd or word access");
    ce_even_a: assert property (
      $past(clk_en_i) && !ce1_n_o[s] |-> $past(acc_req_i[s]))
      else $error("first enable without access");
    rst_seat_a: assert property (
      $past(clk_en_i) && card_rst_oe_o[s] |->
      $past(!cd1_n_i[s] && !cd2_n_i[s]))
      else $error("reset driven into empty socket");
    rst_quiet_a: assert property (
      !card_rst_oe_o[s] |-> !card_rst_o[s])
      else $error("reset value while not driven");
    wake_ring_a: assert property (
      $past(clk_en_i) && wake_o[s] |-> $past(!bvd1_i[s]))
      else $error("wake without ring input");
    led_act_a: assert property (
      $past(clk_en_i) && led_o[s] |-> $past(!bvd2_i[s]))
      else $error("led without drive activity");
  end
endmodule

bind sock_ctl sock_ctl_properties u_props (.*);

// [dv/card_model.sv]
// Behavioural inserted card driving the socket sense pins
`timescale 1ns/1ps
module card_model
  import sock_ctl_pkg::*;
(
  // Bench controls
  input  wire logic [NUM_SOCK-1:0]   seated_i,
  input  wire logic [2*NUM_SOCK-1:0] vs_code_i,
  input  wire logic [NUM_SOCK-1:0]   bvd1_lvl_i,
  input  wire logic [NUM_SOCK-1:0]   bvd2_lvl_i,
  // Socket pins
  output logic      [NUM_SOCK-1:0]   cd1_n_o,
  output logic      [NUM_SOCK-1:0]   cd2_n_o,
  output logic      [NUM_SOCK-1:0]   vs1_o,
  output logic      [NUM_SOCK-1:0]   vs2_o,
  output logic      [NUM_SOCK-1:0]   bvd1_o,
  output logic      [NUM_SOCK-1:0]   bvd2_o
);
  // Empty socket: pulled-up pins read high
  always_comb begin
    for (int s = 0; s < NUM_SOCK; s++) begin
      cd1_n_o[s] = !seated_i[s];
      cd2_n_o[s] = !seated_i[s];
      vs1_o[s]   = !seated_i[s] || vs_code_i[2*s];
      vs2_o[s]   = !seated_i[s] || vs_code_i[2*s+1];
      bvd1_o[s]  = !seated_i[s] || bvd1_lvl_i[s];
      bvd2_o[s]  = !seated_i[s] || bvd2_lvl_i[s];
    end
  end
endmodule

// [dv/tb_sock_ctl.sv]
// Self-checking bench for the socket control block
`timescale 1ns/1ps
module tb_sock_ctl;
  import sock_ctl_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  error_cnt++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
  end end
  logic                core_clk_i = 1'b0;
  logic                rst_n_i    = 1'b0;
  logic                clk_en_i   = 1'b1;
  logic [AW-1:0]       reg_addr_i = '0;
  logic [DW-1:0]       reg_wdata_i = '0;
  logic                reg_wr_i   = 1'b0;
  logic                reg_rd_i   = 1'b0;
  logic [NUM_SOCK-1:0] acc_req_i = '0, acc_word_i = '0, acc_a0_i = '0;
  logic [NUM_SOCK-1:0] seated = '0, b1 = '1, b2 = '1;
  logic [3:0]          vsc = 4'hF;
  logic [DW-1:0]       d;
  logic [1:0]          c, m, ce_e;
  logic                b8;
  logic [3:0]          rexp = 4'b1001;
  logic [DW-1:0]       rtab [4] = '{32'h38, 32'h30, 32'h3A, 32'h32};
  wire  [NUM_SOCK-1:0] cd1, cd2, vs1, vs2, bv1, bv2, ce1, ce2;
  wire  [NUM_SOCK-1:0] rst, oe, pu, led, spk, wk;
  wire  [DW-1:0]       rdata;
  wire                 irq;
  int                  error_cnt = 0;
  int                  samples_checked = 0;

  always #25 core_clk_i = !core_clk_i;

  card_model card (.seated_i(seated), .vs_code_i(vsc), .bvd1_lvl_i(b1),
    .bvd2_lvl_i(b2), .cd1_n_o(cd1), .cd2_n_o(cd2), .vs1_o(vs1), .vs2_o(vs2),
    .bvd1_o(bv1), .bvd2_o(bv2));
  sock_ctl dut (.core_clk_i, .rst_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata), .irq_o(irq), .acc_req_i,
    .acc_word_i, .acc_a0_i, .cd1_n_i(cd1), .cd2_n_i(cd2), .vs1_i(vs1),
    .vs2_i(vs2), .bvd1_i(bv1), .bvd2_i(bv2), .ce1_n_o(ce1), .ce2_n_o(ce2),
    .card_rst_o(rst), .card_rst_oe_o(oe), .vs_pu_en_o(pu), .spkr_o(spk),
    .led_o(led), .wake_o(wk));

  function automatic logic [1:0] ce_exp(input logic q, w, a, e, cbm);
    if (!q || cbm) return 2'b11;
    if (e || w) return e ? 2'b10 : 2'b00;
    return a ? 2'b01 : 2'b10;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    void'($urandom(74));
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    foreach (rtab[i]) begin
      rd(AW'(i * 3));
      `CHK(d, 32'h0)
    end
    c = 2'($urandom_range(2, 0));
    @(posedge core_clk_i);
    {seated, vsc, b1, b2} <= {2'b01, 2'b11, c, 2'b10, 2'b10};
    tick(3);
    rd(OFF_STAT0);
    `CHK(d, 32'h31 | {c, 2'b00})
    rd(OFF_IRQ_ST);
    `CHK(d, 32'h1)
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_MK, 32'h1);
    tick(2);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_ST, 32'h1);
    tick(2);
    `CHK(irq, 1'b0)
    wr(OFF_CTRL0, 32'h141);
    tick(2);
    `CHK(led[0], 1'b1)
    `CHK(spk[0], 1'b1)
    rd(OFF_STAT0);
    `CHK(d[7:4], 4'h4)
    wr(OFF_CTRL0, 32'h81);
    rd(OFF_STAT0);
    `CHK(d[7:4], 4'h8)
    `CHK(wk[0], 1'b1)
    `CHK(spk[0], 1'b0)
    wr(OFF_CTRL0, 32'h2);
    @(posedge core_clk_i);
    {b1, b2} <= 4'b1011;
    tick(2);
    rd(OFF_STAT0);
    `CHK(d, 32'h243 | {c, 2'b00})
    `CHK(d[6], 1'b1)
    `CHK(wk[0], 1'b0)
    repeat (16) begin
      m  = 2'($urandom_range(2, 0));
      b8 = 1'($urandom_range(1, 0));
      wr(OFF_CTRL0, {b8, m});
      wr(OFF_CTRL1, {b8, m});
      @(posedge core_clk_i);
      {acc_req_i, acc_word_i, acc_a0_i} <= 6'($urandom);
      tick(1);
      for (int s = 0; s < NUM_SOCK; s++) begin
        ce_e = ce_exp(acc_req_i[s], acc_word_i[s], acc_a0_i[s], b8,
                      m == MODE_CB);
        `CHK({ce2[s], ce1[s]}, ce_e)
      end
    end
    foreach (rtab[i]) begin
      wr(OFF_CTRL0, rtab[i]);
      wr(OFF_CTRL1, rtab[i]);
      tick(2);
      `CHK(oe, 2'b01)
      `CHK(rst[0], rexp[i])
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL0, DW'(i) << 9);
      tick(2);
      `CHK(pu[0], i == 3)
    end
    @(posedge core_clk_i);
    clk_en_i  <= 1'b0;
    acc_req_i <= ~acc_req_i;
    repeat (3) @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    seated   <= '0;
    tick(3);
    rd(OFF_IRQ_ST);
    `CHK(d[1], 1'b1)
    give_verdict();
  end
endmodule
